// ===== rtl/srpc_pkg.sv
// Purpose: Shared constants and types for the source-route port configuration store
// Assumes: Fixed port count, one clock domain
// Notes: Port type vector marks which ports do source routing
package srpc_pkg;
    localparam int unsigned SRPC_NPORTS = 4;
    localparam int unsigned SRPC_PW = 2;
    localparam int unsigned SRPC_NPAIRS = SRPC_NPORTS * SRPC_NPORTS;
    localparam int unsigned SRPC_PAIRW = 2 * SRPC_PW;
    localparam int unsigned SRPC_CNTW = SRPC_PAIRW + 1;
    localparam int unsigned SRPC_LANW = 12;
    localparam int unsigned SRPC_MSDUW = 16;
    localparam int unsigned SRPC_LIMW = 4;
    localparam int unsigned SRPC_BNW = 4;
    localparam int unsigned SRPC_RIFW = 5;
    localparam int unsigned SRPC_PRIOW = 3;
    localparam int unsigned SRPC_DATAW = 32;
    localparam logic [SRPC_LIMW-1:0] SRPC_RD_LIM_MAX = 4'hE;
    localparam logic [SRPC_LIMW-1:0] SRPC_RD_LIM_RST = 4'h7;
    localparam logic [SRPC_LANW-1:0] SRPC_LAN_RST = 12'h000;
    localparam logic [SRPC_MSDUW-1:0] SRPC_MSDU_RST = 16'h05DC;
    localparam logic [SRPC_BNW-1:0] SRPC_BN_RST = 4'h0;
    localparam logic [SRPC_RIFW-1:0] SRPC_RIF_LEN_MIN = 5'h04;
    localparam logic [SRPC_NPORTS-1:0] SRPC_PORT_SRT = 4'hF;

    typedef enum logic {
        SRPC_PT_TB = 1'b0,
        SRPC_PT_SRT = 1'b1
    } srpc_port_type_t;

    typedef enum logic {
        SRPC_LIM_ARE = 1'b0,
        SRPC_LIM_STE = 1'b1
    } srpc_lim_sel_t;

    typedef enum logic {
        SRPC_LF_BASE = 1'b0,
        SRPC_LF_EXT = 1'b1
    } srpc_lf_mode_t;

    typedef enum logic [1:0] {
        SRPC_FK_NSR = 2'b00,
        SRPC_FK_SRF = 2'b01,
        SRPC_FK_ARE = 2'b10,
        SRPC_FK_STE = 2'b11
    } srpc_frame_kind_t;
endpackage : srpc_pkg

// ===== rtl/srpc_filt_if.sv
// Purpose: Carries limits and frame facts between the store and the explorer filter
// Assumes: Same clock on both sides
// Notes: Purely combinational signals
`timescale 1ns/1ps
interface srpc_filt_if;
    import srpc_pkg::*;
    logic [SRPC_LIMW-1:0] are_lim;
    logic [SRPC_LIMW-1:0] ste_lim;
    logic lth4_en;
    srpc_frame_kind_t kind;
    logic [SRPC_LIMW:0] rd_cnt;
    logic [SRPC_RIFW-1:0] rif_len;
    logic pass;
    modport ctl (output are_lim, output ste_lim, output lth4_en, output kind,
        output rd_cnt, output rif_len, input pass);
    modport filt (input are_lim, input ste_lim, input lth4_en, input kind,
        input rd_cnt, input rif_len, output pass);
endinterface : srpc_filt_if

// ===== rtl/srpc_explorer_filter.sv
// Purpose: Decides whether a frame may be relayed against the explorer limits
// Assumes: Route descriptor count already extracted by the parser
// Notes: Non-explorer frames always pass
`timescale 1ns/1ps
module srpc_explorer_filter
    import srpc_pkg::*;
(
    // Limits and frame facts
    srpc_filt_if.filt f
);
    import srpc_pkg::*;

    logic short_rif;

    always_comb
    begin
        short_rif = (f.rif_len == SRPC_RIF_LEN_MIN);
        unique case (f.kind)
            SRPC_FK_ARE:
            begin
                f.pass = (f.rd_cnt <= {1'b0, f.are_lim})
                    && (!short_rif || f.lth4_en);
            end
            SRPC_FK_STE:
            begin
                f.pass = (f.rd_cnt <= {1'b0, f.ste_lim})
                    && (!short_rif || f.lth4_en);
            end
            SRPC_FK_NSR, SRPC_FK_SRF:
            begin
                f.pass = 1'b1;
            end
        endcase
    end
endmodule : srpc_explorer_filter

// ===== rtl/srpc_port_config.sv
// Purpose: Per-port source-route settings, port-pair table and relay gate
// Assumes: Management strobes are one-cycle pulses on i_clock
// Notes: Relay holds one frame, so frames leave in arrival order
//
// Functional notes
// - Store 12-bit LAN identifier per port
// - Store writable largest payload size per port
// - Limit write selects ARE or STE limit
// - Drop ARE frames over ARE limit
// - Drop STE frames over STE limit
// - Port read returns type, LAN, size, limits
// - Report count of port-pair table entries
// - Pair read returns bridge number and state
// - Pair write stores bridge number and state
// - Keep order of same-priority relayed frames
// - Submit each frame to MAC once
// - Optionally forward explorers with length four
// - Readable writable largest-frame encoding mode
`timescale 1ns/1ps
module srpc_port_config
    import srpc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Bridge-wide settings
    input wire logic i_lf_mode_wr,
    input wire srpc_lf_mode_t i_lf_mode,
    output srpc_lf_mode_t o_lf_mode,
    input wire logic i_lth4_en,
    // Per-port writes
    input wire logic i_lan_wr,
    input wire logic i_msdu_wr,
    input wire logic i_lim_wr,
    input wire logic [srpc_pkg::SRPC_PW-1:0] i_wr_port,
    input wire logic [srpc_pkg::SRPC_LANW-1:0] i_lan_id,
    input wire logic [srpc_pkg::SRPC_MSDUW-1:0] i_msdu_size,
    input wire srpc_lim_sel_t i_lim_sel,
    input wire logic [srpc_pkg::SRPC_LIMW-1:0] i_lim_val,
    output logic o_lim_reject,
    // Port parameter read
    input wire logic [srpc_pkg::SRPC_PW-1:0] i_rd_port,
    output srpc_port_type_t o_rd_type,
    output logic [srpc_pkg::SRPC_LANW-1:0] o_rd_lan_id,
    output logic [srpc_pkg::SRPC_MSDUW-1:0] o_rd_msdu_size,
    output logic [srpc_pkg::SRPC_LIMW-1:0] o_rd_are_lim,
    output logic [srpc_pkg::SRPC_LIMW-1:0] o_rd_ste_lim,
    // Port-pair table
    input wire logic i_pair_wr,
    input wire logic [srpc_pkg::SRPC_PW-1:0] i_pair_lo,
    input wire logic [srpc_pkg::SRPC_PW-1:0] i_pair_hi,
    input wire logic [srpc_pkg::SRPC_BNW-1:0] i_pair_bn,
    input wire logic i_pair_en,
    output logic [srpc_pkg::SRPC_BNW-1:0] o_pair_bn,
    output logic o_pair_en,
    output logic [srpc_pkg::SRPC_CNTW-1:0] o_pair_count,
    // Relay frames in
    input wire logic i_frm_valid,
    output logic o_frm_ready,
    input wire srpc_frame_kind_t i_frm_kind,
    input wire logic [srpc_pkg::SRPC_LIMW:0] i_frm_rd_cnt,
    input wire logic [srpc_pkg::SRPC_RIFW-1:0] i_frm_rif_len,
    input wire logic [srpc_pkg::SRPC_PRIOW-1:0] i_frm_prio,
    input wire logic [srpc_pkg::SRPC_DATAW-1:0] i_frm_tag,
    output logic o_frm_drop,
    // MAC submission
    output logic o_mac_valid,
    input wire logic i_mac_ready,
    output srpc_frame_kind_t o_mac_kind,
    output logic [srpc_pkg::SRPC_PRIOW-1:0] o_mac_prio,
    output logic [srpc_pkg::SRPC_DATAW-1:0] o_mac_tag
);
    import srpc_pkg::*;

    function automatic logic [SRPC_PAIRW-1:0] pair_idx(
        input logic [SRPC_PW-1:0] lo,
        input logic [SRPC_PW-1:0] hi
    );
        pair_idx = {lo, hi};
    endfunction : pair_idx

    srpc_lf_mode_t lf_q;
    srpc_lf_mode_t lf_d;
    logic [SRPC_LANW-1:0] lan_q [SRPC_NPORTS];
    logic [SRPC_LANW-1:0] lan_d [SRPC_NPORTS];
    logic [SRPC_MSDUW-1:0] msdu_q [SRPC_NPORTS];
    logic [SRPC_MSDUW-1:0] msdu_d [SRPC_NPORTS];
    logic [SRPC_LIMW-1:0] are_q [SRPC_NPORTS];
    logic [SRPC_LIMW-1:0] are_d [SRPC_NPORTS];
    logic [SRPC_LIMW-1:0] ste_q [SRPC_NPORTS];
    logic [SRPC_LIMW-1:0] ste_d [SRPC_NPORTS];
    logic lim_ok;
    logic rej_q;
    logic rej_d;
    srpc_port_type_t rtype_d;

    always_comb
    begin
        lf_d = i_lf_mode_wr ? i_lf_mode : lf_q;
        lim_ok = (i_lim_val <= SRPC_RD_LIM_MAX);
        rej_d = i_lim_wr && !lim_ok;
        rtype_d = SRPC_PORT_SRT[i_rd_port] ? SRPC_PT_SRT : SRPC_PT_TB;
    end

    genvar gp;
    generate
        for (gp = 0; gp < SRPC_NPORTS; gp++)
        begin : g_port
            logic sel;
            always_comb
            begin
                sel = (i_wr_port == SRPC_PW'(gp));
                lan_d[gp] = (i_lan_wr && sel) ? i_lan_id : lan_q[gp];
                msdu_d[gp] = (i_msdu_wr && sel) ? i_msdu_size : msdu_q[gp];
                are_d[gp] = are_q[gp];
                ste_d[gp] = ste_q[gp];
                if (i_lim_wr && sel && lim_ok)
                begin
                    if (i_lim_sel == SRPC_LIM_ARE)
                    begin
                        are_d[gp] = i_lim_val;
                    end
                    else
                    begin
                        ste_d[gp] = i_lim_val;
                    end
                end
            end
            always_ff @(posedge i_clock)
            begin
                if (i_sys_rst)
                begin
                    lan_q[gp] <= SRPC_LAN_RST;
                    msdu_q[gp] <= SRPC_MSDU_RST;
                    are_q[gp] <= SRPC_RD_LIM_RST;
                    ste_q[gp] <= SRPC_RD_LIM_RST;
                end
                else
                begin
                    lan_q[gp] <= lan_d[gp];
                    msdu_q[gp] <= msdu_d[gp];
                    are_q[gp] <= are_d[gp];
                    ste_q[gp] <= ste_d[gp];
                end
            end
        end
    endgenerate

    // Port parameter read, registered
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            lf_q <= SRPC_LF_BASE;
            rej_q <= 1'b0;
            o_rd_type <= SRPC_PT_TB;
            o_rd_lan_id <= SRPC_LAN_RST;
            o_rd_msdu_size <= SRPC_MSDU_RST;
            o_rd_are_lim <= SRPC_RD_LIM_RST;
            o_rd_ste_lim <= SRPC_RD_LIM_RST;
        end
        else
        begin
            lf_q <= lf_d;
            rej_q <= rej_d;
            o_rd_type <= rtype_d;
            o_rd_lan_id <= lan_q[i_rd_port];
            o_rd_msdu_size <= msdu_q[i_rd_port];
            o_rd_are_lim <= are_q[i_rd_port];
            o_rd_ste_lim <= ste_q[i_rd_port];
        end
    end

    assign o_lf_mode = lf_q;
    assign o_lim_reject = rej_q;

    // Port-pair table; an entry counts once it has been written
    logic [SRPC_BNW-1:0] bn_q [SRPC_NPAIRS];
    logic [SRPC_BNW-1:0] bn_d [SRPC_NPAIRS];
    logic [SRPC_NPAIRS-1:0] en_q;
    logic [SRPC_NPAIRS-1:0] en_d;
    logic [SRPC_NPAIRS-1:0] used_q;
    logic [SRPC_NPAIRS-1:0] used_d;
    logic [SRPC_CNTW-1:0] cnt_d;
    logic [SRPC_PAIRW-1:0] widx;

    always_comb
    begin
        widx = pair_idx(i_pair_lo, i_pair_hi);
        en_d = en_q;
        used_d = used_q;
        cnt_d = '0;
        for (int i = 0; i < SRPC_NPAIRS; i++)
        begin
            bn_d[i] = bn_q[i];
            cnt_d = cnt_d + SRPC_CNTW'(used_q[i]);
        end
        if (i_pair_wr)
        begin
            bn_d[widx] = i_pair_bn;
            en_d[widx] = i_pair_en;
            used_d[widx] = 1'b1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            en_q <= '0;
            used_q <= '0;
            for (int i = 0; i < SRPC_NPAIRS; i++)
            begin
                bn_q[i] <= SRPC_BN_RST;
            end
            o_pair_bn <= SRPC_BN_RST;
            o_pair_en <= 1'b0;
            o_pair_count <= '0;
        end
        else
        begin
            en_q <= en_d;
            used_q <= used_d;
            for (int i = 0; i < SRPC_NPAIRS; i++)
            begin
                bn_q[i] <= bn_d[i];
            end
            o_pair_bn <= bn_q[widx];
            o_pair_en <= en_q[widx];
            o_pair_count <= cnt_d;
        end
    end

    // Relay gate: one slot, so order is kept for every priority
    srpc_filt_if f ();
    srpc_explorer_filter u_filt (
        .f(f)
    );

    assign f.are_lim = are_q[i_wr_port];
    assign f.ste_lim = ste_q[i_wr_port];
    assign f.lth4_en = i_lth4_en;
    assign f.kind = i_frm_kind;
    assign f.rd_cnt = i_frm_rd_cnt;
    assign f.rif_len = i_frm_rif_len;

    logic mv_q;
    logic mv_d;
    srpc_frame_kind_t mk_q;
    srpc_frame_kind_t mk_d;
    logic [SRPC_PRIOW-1:0] mp_q;
    logic [SRPC_PRIOW-1:0] mp_d;
    logic [SRPC_DATAW-1:0] mt_q;
    logic [SRPC_DATAW-1:0] mt_d;
    logic take;

    always_comb
    begin
        o_frm_ready = !mv_q || i_mac_ready;
        take = i_frm_valid && o_frm_ready;
        o_frm_drop = take && !f.pass;
        mv_d = mv_q && !i_mac_ready;
        mk_d = mk_q;
        mp_d = mp_q;
        mt_d = mt_q;
        if (take && f.pass)
        begin
            mv_d = 1'b1;
            mk_d = i_frm_kind;
            mp_d = i_frm_prio;
            mt_d = i_frm_tag;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            mv_q <= 1'b0;
            mk_q <= SRPC_FK_NSR;
            mp_q <= '0;
            mt_q <= '0;
        end
        else
        begin
            mv_q <= mv_d;
            mk_q <= mk_d;
            mp_q <= mp_d;
            mt_q <= mt_d;
        end
    end

    assign o_mac_valid = mv_q;
    assign o_mac_kind = mk_q;
    assign o_mac_prio = mp_q;
    assign o_mac_tag = mt_q;
endmodule : srpc_port_config

// ===== dv/srpc_port_config_properties.sv
// Purpose: Port-level properties of the port config store
// Assumes: Reset held for at least two cycles
// Notes: Limit drop checks use the fixed maximum limit
`timescale 1ns/1ps
module srpc_port_config_properties
    import srpc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Settings
    input wire logic i_lf_mode_wr,
    input wire srpc_pkg::srpc_lf_mode_t i_lf_mode,
    input wire srpc_pkg::srpc_lf_mode_t o_lf_mode,
    input wire logic i_lth4_en,
    input wire logic i_lim_wr,
    input wire logic [srpc_pkg::SRPC_PW-1:0] i_wr_port,
    input wire srpc_pkg::srpc_lim_sel_t i_lim_sel,
    input wire logic [srpc_pkg::SRPC_LIMW-1:0] i_lim_val,
    input wire logic o_lim_reject,
    input wire logic [srpc_pkg::SRPC_PW-1:0] i_rd_port,
    input wire logic [srpc_pkg::SRPC_LIMW-1:0] o_rd_are_lim,
    input wire logic [srpc_pkg::SRPC_CNTW-1:0] o_pair_count,
    // Relay
    input wire logic i_frm_valid,
    input wire logic o_frm_ready,
    input wire srpc_pkg::srpc_frame_kind_t i_frm_kind,
    input wire logic [srpc_pkg::SRPC_LIMW:0] i_frm_rd_cnt,
    input wire logic [srpc_pkg::SRPC_RIFW-1:0] i_frm_rif_len,
    input wire logic o_frm_drop,
    input wire logic o_mac_valid,
    input wire logic i_mac_ready,
    input wire logic [srpc_pkg::SRPC_DATAW-1:0] o_mac_tag
);
    import srpc_pkg::*;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    logic take;
    logic expl;
    assign take = i_frm_valid && o_frm_ready;
    assign expl = i_frm_kind == SRPC_FK_ARE || i_frm_kind == SRPC_FK_STE;
    property p_lim_rej;
        i_lim_wr && i_lim_val > SRPC_RD_LIM_MAX |=> o_lim_reject;
    endproperty
    a_lim_rej: assert property (p_lim_rej) else $error("limit not refused");
    property p_lim_ok;
        !(i_lim_wr && i_lim_val > SRPC_RD_LIM_MAX) |=> !o_lim_reject;
    endproperty
    a_lim_ok: assert property (p_lim_ok) else $error("spurious refusal");
    property p_are_store;
        i_lim_wr && i_lim_val <= SRPC_RD_LIM_MAX && i_lim_sel == SRPC_LIM_ARE
            ##1 !i_lim_wr && i_rd_port == $past(i_wr_port)
            |=> o_rd_are_lim == $past(i_lim_val, 2);
    endproperty
    a_are_store: assert property (p_are_store) else $error("limit not stored");
    property p_drop_are;
        take && i_frm_kind == SRPC_FK_ARE && i_frm_rd_cnt > {1'b0, SRPC_RD_LIM_MAX} |-> o_frm_drop;
    endproperty
    a_drop_are: assert property (p_drop_are) else $error("long ARE relayed");
    property p_drop_ste;
        take && i_frm_kind == SRPC_FK_STE && i_frm_rd_cnt > {1'b0, SRPC_RD_LIM_MAX} |-> o_frm_drop;
    endproperty
    a_drop_ste: assert property (p_drop_ste) else $error("long STE relayed");
    property p_lth4;
        take && expl && i_frm_rif_len == SRPC_RIF_LEN_MIN && !i_lth4_en |-> o_frm_drop;
    endproperty
    a_lth4: assert property (p_lth4) else $error("length four relayed");
    property p_mac_hold;
        o_mac_valid && !i_mac_ready |=> o_mac_valid && $stable(o_mac_tag);
    endproperty
    a_mac_hold: assert property (p_mac_hold) else $error("MAC offer lost");
    property p_count;
        o_pair_count != $past(o_pair_count) |-> o_pair_count == $past(o_pair_count) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("count jumped");
    property p_lf;
        i_lf_mode_wr |=> o_lf_mode == $past(i_lf_mode);
    endproperty
    a_lf: assert property (p_lf) else $error("mode not stored");
    c_rej: cover property (i_lim_wr && i_lim_val > SRPC_RD_LIM_MAX);
    c_drop: cover property (take && o_frm_drop);
    c_stall: cover property (o_mac_valid && !i_mac_ready);
endmodule : srpc_port_config_properties

bind srpc_port_config srpc_port_config_properties u_props (
    .i_clock, .i_sys_rst, .i_lf_mode_wr, .i_lf_mode, .o_lf_mode, .i_lth4_en,
    .i_lim_wr, .i_wr_port, .i_lim_sel, .i_lim_val, .o_lim_reject, .i_rd_port,
    .o_rd_are_lim, .o_pair_count, .i_frm_valid, .o_frm_ready, .i_frm_kind,
    .i_frm_rd_cnt, .i_frm_rif_len, .o_frm_drop, .o_mac_valid, .i_mac_ready, .o_mac_tag
);

// ===== dv/test_srpc_port_config.sv
// Purpose: Self-checking bench for the port config store
// Assumes: Inputs change on rising edges by non-blocking assignment
// Notes: A monitor checks MAC submissions against the expected order
`timescale 1ns/1ps
module test_srpc_port_config;
    import srpc_pkg::*;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_lf_mode_wr = 1'b0, i_lth4_en = 1'b0;
    logic i_lan_wr = 1'b0, i_msdu_wr = 1'b0, i_lim_wr = 1'b0, i_pair_wr = 1'b0;
    logic i_pair_en = 1'b0, i_frm_valid = 1'b0, i_mac_ready = 1'b1;
    logic [1:0] i_wr_port = 2'h0, i_rd_port = 2'h0, i_pair_lo = 2'h0, i_pair_hi = 2'h0;
    logic [3:0] i_lim_val = 4'h0, i_pair_bn = 4'h0;
    logic [11:0] i_lan_id = 12'h000;
    logic [15:0] i_msdu_size = 16'h0000;
    logic [4:0] i_frm_rd_cnt = 5'h00, i_frm_rif_len = 5'h00;
    logic [2:0] i_frm_prio = 3'h0;
    logic [31:0] i_frm_tag = 32'h0, tag_n = 32'h100;
    srpc_lf_mode_t i_lf_mode = SRPC_LF_BASE;
    srpc_lim_sel_t i_lim_sel = SRPC_LIM_ARE;
    srpc_frame_kind_t i_frm_kind = SRPC_FK_NSR;
    srpc_lf_mode_t o_lf_mode;
    srpc_port_type_t o_rd_type;
    srpc_frame_kind_t o_mac_kind;
    logic o_lim_reject, o_pair_en, o_frm_ready, o_frm_drop, o_mac_valid;
    logic [11:0] o_rd_lan_id;
    logic [15:0] o_rd_msdu_size;
    logic [3:0] o_rd_are_lim, o_rd_ste_lim, o_pair_bn;
    logic [4:0] o_pair_count;
    logic [2:0] o_mac_prio;
    logic [31:0] o_mac_tag;
    logic [31:0] expq[$];
    srpc_frame_kind_t kq[$];
    logic [31:0] exp_tag;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    srpc_port_config dut (
        .i_clock, .i_sys_rst, .i_lf_mode_wr, .i_lf_mode, .o_lf_mode, .i_lth4_en,
        .i_lan_wr, .i_msdu_wr, .i_lim_wr, .i_wr_port, .i_lan_id, .i_msdu_size,
        .i_lim_sel, .i_lim_val, .o_lim_reject, .i_rd_port, .o_rd_type, .o_rd_lan_id,
        .o_rd_msdu_size, .o_rd_are_lim, .o_rd_ste_lim, .i_pair_wr, .i_pair_lo,
        .i_pair_hi, .i_pair_bn, .i_pair_en, .o_pair_bn, .o_pair_en, .o_pair_count,
        .i_frm_valid, .o_frm_ready, .i_frm_kind, .i_frm_rd_cnt, .i_frm_rif_len,
        .i_frm_prio, .i_frm_tag, .o_frm_drop, .o_mac_valid, .i_mac_ready,
        .o_mac_kind, .o_mac_prio, .o_mac_tag
    );

    always #5 i_clock = ~i_clock;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s exp %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic wr_cfg(input logic [1:0] p, input logic [11:0] lan, input logic [15:0] sz);
        i_wr_port <= p;
        i_lan_id <= lan;
        i_msdu_size <= sz;
        i_lan_wr <= 1'b1;
        i_msdu_wr <= 1'b1;
        @(posedge i_clock);
        i_lan_wr <= 1'b0;
        i_msdu_wr <= 1'b0;
        @(posedge i_clock);
    endtask : wr_cfg

    task automatic wr_lim(input logic [1:0] p, input srpc_lim_sel_t s, input logic [3:0] v);
        i_wr_port <= p;
        i_lim_sel <= s;
        i_lim_val <= v;
        i_lim_wr <= 1'b1;
        @(posedge i_clock);
        i_lim_wr <= 1'b0;
        @(negedge i_clock);
        check("lim_reject", o_lim_reject, v > 4'hE);
        @(posedge i_clock);
    endtask : wr_lim

    task automatic rd_chk(input logic [1:0] p, input logic [11:0] lan, input logic [15:0] sz,
        input logic [3:0] are, input logic [3:0] ste);
        i_rd_port <= p;
        @(posedge i_clock);
        @(negedge i_clock);
        check("rd_type", o_rd_type, SRPC_PT_SRT);
        check("rd_lan", o_rd_lan_id, lan);
        check("rd_msdu", o_rd_msdu_size, sz);
        check("rd_are", o_rd_are_lim, are);
        check("rd_ste", o_rd_ste_lim, ste);
        @(posedge i_clock);
    endtask : rd_chk

    task automatic wr_pair(input logic [1:0] lo, hi, input logic [3:0] bn, input logic en);
        i_pair_lo <= lo;
        i_pair_hi <= hi;
        i_pair_bn <= bn;
        i_pair_en <= en;
        i_pair_wr <= 1'b1;
        @(posedge i_clock);
        i_pair_wr <= 1'b0;
        @(posedge i_clock);
    endtask : wr_pair

    task automatic chk_pair(input logic [1:0] lo, hi, input logic [3:0] bn, input logic en,
        input logic [4:0] cnt);
        i_pair_lo <= lo;
        i_pair_hi <= hi;
        @(posedge i_clock);
        @(negedge i_clock);
        check("pair_bn", o_pair_bn, bn);
        check("pair_en", o_pair_en, en);
        check("pair_count", o_pair_count, cnt);
        @(posedge i_clock);
    endtask : chk_pair

    task automatic set_lf(input srpc_lf_mode_t m);
        i_lf_mode <= m;
        i_lf_mode_wr <= 1'b1;
        @(posedge i_clock);
        i_lf_mode_wr <= 1'b0;
        @(negedge i_clock);
        check("lf_mode", o_lf_mode, m);
        @(posedge i_clock);
    endtask : set_lf

    // Leaves valid high so that frames can follow back to back
    task automatic send(input srpc_frame_kind_t k, input logic [4:0] c, r, input logic d);
        i_frm_valid <= 1'b1;
        i_frm_kind <= k;
        i_frm_rd_cnt <= c;
        i_frm_rif_len <= r;
        i_frm_tag <= tag_n;
        i_frm_prio <= tag_n[2:0];
        @(negedge i_clock);
        while (o_frm_ready !== 1'b1)
        begin
            @(negedge i_clock);
        end
        check("frm_drop", o_frm_drop, d);
        if (!d)
        begin
            expq.push_back(tag_n);
            kq.push_back(k);
        end
        tag_n++;
        @(posedge i_clock);
    endtask : send

    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (o_mac_valid === 1'b1 && i_mac_ready === 1'b1)
        begin
            if (expq.size() == 0)
                check("mac_extra", 32'h1, 32'h0);
            else
            begin
                exp_tag = expq.pop_front();
                check("mac_tag", o_mac_tag, exp_tag);
                check("mac_prio", o_mac_prio, exp_tag[2:0]);
                check("mac_kind", o_mac_kind, kq.pop_front());
            end
        end
        if (cycles == 2000)
        begin
            err_count++;
            stop_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        for (int p = 0; p < 4; p++)
            rd_chk(2'(p), 12'h000, 16'h05DC, 4'h7, 4'h7);
        chk_pair(2'h3, 2'h3, 4'h0, 1'b0, 5'h00);
        for (int p = 0; p < 4; p++)
        begin
            wr_cfg(2'(p), 12'hA50 + 12'(p), 16'h0800 + 16'(p));
            wr_lim(2'(p), SRPC_LIM_ARE, 4'(p));
            wr_lim(2'(p), SRPC_LIM_STE, 4'hE);
        end
        wr_lim(2'h0, SRPC_LIM_STE, 4'hF);
        for (int p = 0; p < 4; p++)
            rd_chk(2'(p), 12'hA50 + 12'(p), 16'h0800 + 16'(p), 4'(p), 4'hE);
        wr_pair(2'h0, 2'h1, 4'h5, 1'b1);
        wr_pair(2'h2, 2'h3, 4'hA, 1'b1);
        wr_pair(2'h0, 2'h1, 4'h6, 1'b0);
        chk_pair(2'h0, 2'h1, 4'h6, 1'b0, 5'h02);
        chk_pair(2'h2, 2'h3, 4'hA, 1'b1, 5'h02);
        chk_pair(2'h1, 2'h0, 4'h0, 1'b0, 5'h02);
        set_lf(SRPC_LF_EXT);
        set_lf(SRPC_LF_BASE);
        // Port 1 limits: ARE 1, STE 14
        i_wr_port <= 2'h1;
        send(SRPC_FK_NSR, 5'h09, 5'h00, 1'b0);
        send(SRPC_FK_SRF, 5'h09, 5'h06, 1'b0);
        send(SRPC_FK_ARE, 5'h01, 5'h06, 1'b0);
        send(SRPC_FK_ARE, 5'h02, 5'h06, 1'b1);
        send(SRPC_FK_ARE, 5'h10, 5'h06, 1'b1);
        send(SRPC_FK_STE, 5'h0E, 5'h06, 1'b0);
        send(SRPC_FK_STE, 5'h0F, 5'h06, 1'b1);
        send(SRPC_FK_ARE, 5'h01, 5'h04, 1'b1);
        i_lth4_en <= 1'b1;
        send(SRPC_FK_STE, 5'h01, 5'h04, 1'b0);
        i_frm_valid <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_mac_ready <= 1'b0;
        send(SRPC_FK_SRF, 5'h01, 5'h06, 1'b0);
        i_frm_valid <= 1'b0;
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        check("mac_stands", o_mac_valid, 1'b1);
        check("frm_ready", o_frm_ready, 1'b0);
        @(posedge i_clock);
        i_mac_ready <= 1'b1;
        repeat (3) @(posedge i_clock);
        check("queue_left", expq.size(), 32'h0);
        stop_test();
    end
endmodule : test_srpc_port_config
